// *** hdl/bst_defs.vh ***
/*
 * Constants for the boundary-scan test port: instruction codes, TAP state
 * codes, chain layout and reset values.
 * Assumes it is included by bare name into the test-port modules.
 */
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

`define BST_IR_LEN        10
`define BST_ID_LEN        32
`define BST_RC_LEN        16

// Instruction codes.
`define BST_OP_EXTEST     10'h00F
`define BST_OP_SAMPLE     10'h005
`define BST_OP_BYPASS     10'h3FF
`define BST_OP_IDCODE     10'h006
`define BST_OP_USERCODE   10'h007
`define BST_OP_CLAMP      10'h00A
`define BST_OP_HIGHZ      10'h00B
`define BST_OP_RECONFIG   10'h002
`define BST_IR_CAPTURE    10'h001

// Arbitrary identification values.
`define BST_IDCODE_VAL    32'h0000A001
`define BST_USERCODE_VAL  32'hFFFFFFFF

// TAP states, one-hot.
`define BST_ST_RESET      16'h0001
`define BST_ST_IDLE       16'h0002
`define BST_ST_SELDR      16'h0004
`define BST_ST_CAPDR      16'h0008
`define BST_ST_SHDR       16'h0010
`define BST_ST_EX1DR      16'h0020
`define BST_ST_PSDR       16'h0040
`define BST_ST_EX2DR      16'h0080
`define BST_ST_UPDR       16'h0100
`define BST_ST_SELIR      16'h0200
`define BST_ST_CAPIR      16'h0400
`define BST_ST_SHIR       16'h0800
`define BST_ST_EX1IR      16'h1000
`define BST_ST_PSIR       16'h2000
`define BST_ST_EX2IR      16'h4000
`define BST_ST_UPIR       16'h8000

// Cell kinds.
`define BST_KIND_USER     3'h0
`define BST_KIND_CLKIN    3'h1
`define BST_KIND_CFGIN    3'h2
`define BST_KIND_ODBIDIR  3'h3
`define BST_KIND_PPBIDIR  3'h4

`endif

// *** hdl/bst_scan_cell.v ***
/*
 * One three-bit boundary-scan cell with capture and update stages.
 * Assumes the controls are one-cycle enables on the system clock.
 */
`timescale 1ns/100ps
`include "bst_defs.vh"

module bst_scan_cell #(
  parameter [2:0] KIND = `BST_KIND_USER
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Controls
  input  wire       capEn,
  input  wire       shiftEn,
  input  wire       updateEn,
  input  wire       testMode,
  // Serial path
  input  wire       cellSerialIn,
  output wire       cellSerialOut,
  // Core and pad side
  input  wire       coreOutputSignal,
  input  wire       coreOutputEnable,
  input  wire       padIn,
  output wire       padOut,
  output wire       padOeN,
  output wire       coreInputDrive
);

  reg [2:0] capt_r;
  reg [2:0] upd_r;
  reg [2:0] capSrc;

  always @* begin
    case (KIND)
      `BST_KIND_CLKIN, `BST_KIND_CFGIN:
        capSrc = {1'b0, 1'b1, padIn};
      `BST_KIND_ODBIDIR:
        capSrc = {1'b0, coreOutputEnable, padIn};
      default:
        capSrc = {coreOutputSignal, coreOutputEnable, padIn};
    endcase
  end

  // Capture stage bit 0 faces the serial input; bit 2 leaves the cell.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      capt_r <= 3'h0;
      upd_r  <= 3'h2;
    end else begin
      if (capEn)
        capt_r <= capSrc;
      else if (shiftEn)
        capt_r <= {capt_r[1:0], cellSerialIn};
      if (updateEn)
        upd_r <= capt_r;
    end
  end

  assign cellSerialOut = capt_r[2];

  // Update stage of a dedicated cell drives nothing.
  generate
    if (KIND == `BST_KIND_USER) begin : gDrive
      // A one in the enable update stage floats the buffer.
      assign padOut         = testMode ? upd_r[2] : coreOutputSignal;
      assign padOeN         = testMode ? upd_r[1] : coreOutputEnable;
      assign coreInputDrive = testMode ? upd_r[0] : padIn;
    end else begin : gNoDrive
      assign padOut         = coreOutputSignal;
      assign padOeN         = coreOutputEnable;
      assign coreInputDrive = padIn;
    end
  endgenerate

endmodule // bst_scan_cell

// *** hdl/bst_test_port.v ***
/*
 * Boundary-scan test access port: TAP controller, instruction register,
 * bypass, identification, reconfiguration and boundary-scan registers.
 * Assumes the test clock is far slower than clk and is sampled as a level;
 * the test pins are synchronised here before use.
 */
`timescale 1ns/100ps
`include "bst_defs.vh"

module bst_test_port #(
  parameter N_USER = 4
) (
  // System clock and reset
  input  wire              clk,
  input  wire              rst,
  // Test port pins
  input  wire              tck,
  input  wire              tms,
  input  wire              tdi,
  output reg               tdo,
  output reg               tdoOe,
  // User I/O: core side
  input  wire [N_USER-1:0] coreOutputSignal,
  input  wire [N_USER-1:0] coreOutputEnable,
  output reg  [N_USER-1:0] coreInputDrive,
  // User I/O: pad side
  input  wire [N_USER-1:0] padIn,
  output reg  [N_USER-1:0] padOut,
  output reg  [N_USER-1:0] padOe,
  // Dedicated pins
  input  wire              clkPadIn,
  input  wire              cfgPadIn,
  input  wire              odPadIn,
  input  wire              odOeInt,
  input  wire              ppPadIn,
  input  wire              ppOutInt,
  input  wire              ppOeInt,
  // Configuration status
  input  wire              configBusy,
  output reg               configHold,
  output reg               testLogicReset
);

  localparam NC    = N_USER + 4;
  localparam BSLEN = 3 * NC;

  // ==========================================================================
  // Pin synchronisers and test clock edges
  // ==========================================================================
  reg [1:0] tckS_r;
  reg [1:0] tmsS_r;
  reg [1:0] tdiS_r;
  reg [1:0] cfgS_r;
  reg       tckD_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tckS_r <= 2'h0;
      tmsS_r <= 2'h3;
      tdiS_r <= 2'h3;
      cfgS_r <= 2'h0;
      tckD_r <= 1'b0;
    end else begin
      tckS_r <= {tckS_r[0], tck};
      tmsS_r <= {tmsS_r[0], tms};
      tdiS_r <= {tdiS_r[0], tdi};
      cfgS_r <= {cfgS_r[0], configBusy};
      tckD_r <= tckS_r[1];
    end
  end

  // Only four pins; reset comes from mode select or the power-up reset.
  wire tckRise = tckS_r[1] & ~tckD_r;
  wire tckFall = ~tckS_r[1] & tckD_r;
  wire tmsS    = tmsS_r[1];
  wire tdiS    = tdiS_r[1];

  // ==========================================================================
  // Pad input synchronisers
  // ==========================================================================
  // Pad levels change freely; two flops per pin keep the capture stages and
  // the core input path from seeing a metastable sample.
  wire [NC-1:0] padRaw;
  wire [NC-1:0] padSync;

  assign padRaw = {ppPadIn, odPadIn, cfgPadIn, clkPadIn, padIn};

  genvar p;
  generate
    for (p = 0; p < NC; p = p + 1) begin : gPadSync
      reg [1:0] sync_r;

      always @(posedge clk or posedge rst) begin
        if (rst)
          sync_r <= 2'h0;
        else
          sync_r <= {sync_r[0], padRaw[p]};
      end

      assign padSync[p] = sync_r[1];
    end
  endgenerate

  // ==========================================================================
  // TAP controller
  // ==========================================================================
  // TAP states, one-hot.
  localparam [15:0] ST_RESET = `BST_ST_RESET;
  localparam [15:0] ST_IDLE  = `BST_ST_IDLE;
  localparam [15:0] ST_SELDR = `BST_ST_SELDR;
  localparam [15:0] ST_CAPDR = `BST_ST_CAPDR;
  localparam [15:0] ST_SHDR  = `BST_ST_SHDR;
  localparam [15:0] ST_EX1DR = `BST_ST_EX1DR;
  localparam [15:0] ST_PSDR  = `BST_ST_PSDR;
  localparam [15:0] ST_EX2DR = `BST_ST_EX2DR;
  localparam [15:0] ST_UPDR  = `BST_ST_UPDR;
  localparam [15:0] ST_SELIR = `BST_ST_SELIR;
  localparam [15:0] ST_CAPIR = `BST_ST_CAPIR;
  localparam [15:0] ST_SHIR  = `BST_ST_SHIR;
  localparam [15:0] ST_EX1IR = `BST_ST_EX1IR;
  localparam [15:0] ST_PSIR  = `BST_ST_PSIR;
  localparam [15:0] ST_EX2IR = `BST_ST_EX2IR;
  localparam [15:0] ST_UPIR  = `BST_ST_UPIR;

  reg [15:0] state_r;
  reg [15:0] state_nxt;

  always @* begin
    case (state_r)
      ST_RESET: state_nxt = tmsS ? ST_RESET : ST_IDLE;
      ST_IDLE:  state_nxt = tmsS ? ST_SELDR : ST_IDLE;
      ST_SELDR: state_nxt = tmsS ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: state_nxt = tmsS ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  state_nxt = tmsS ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: state_nxt = tmsS ? ST_UPDR  : ST_PSDR;
      ST_PSDR:  state_nxt = tmsS ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: state_nxt = tmsS ? ST_UPDR  : ST_SHDR;
      ST_UPDR:  state_nxt = tmsS ? ST_SELDR : ST_IDLE;
      ST_SELIR: state_nxt = tmsS ? ST_RESET : ST_CAPIR;
      ST_CAPIR: state_nxt = tmsS ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  state_nxt = tmsS ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: state_nxt = tmsS ? ST_UPIR  : ST_PSIR;
      ST_PSIR:  state_nxt = tmsS ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: state_nxt = tmsS ? ST_UPIR  : ST_SHIR;
      ST_UPIR:  state_nxt = tmsS ? ST_SELDR : ST_IDLE;
      default:  state_nxt = ST_RESET;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst)
      state_r <= ST_RESET;
    else if (tckRise)
      state_r <= state_nxt;
  end

  // Controls shared by all registers: the shift selects are state levels, the clocks and strobes last one clk cycle at a rising edge.
  wire dataShiftSelect  = state_r[4];
  wire instrShiftSelect = state_r[11];
  wire dataCapture      = tckRise & state_r[3];
  wire dataShiftClock   = tckRise & dataShiftSelect;
  wire dataUpdateStrobe = tckRise & state_r[8];
  wire instrShiftClock  = tckRise & instrShiftSelect;
  wire instrUpdateStrobe = tckRise & state_r[15];

  // ==========================================================================
  // Instruction register
  // ==========================================================================
  reg [`BST_IR_LEN-1:0] irShift_r;
  reg [`BST_IR_LEN-1:0] ir_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irShift_r <= `BST_IR_CAPTURE;
      ir_r      <= `BST_OP_IDCODE;
    end else begin
      if (tckRise & state_r[10])
        irShift_r <= `BST_IR_CAPTURE;
      else if (instrShiftClock)
        irShift_r <= {tdiS, irShift_r[`BST_IR_LEN-1:1]};
      // Entering reset loads the identify code at once, so pins return to normal with it.
      if (tckRise & state_nxt[0])
        ir_r <= `BST_OP_IDCODE;
      else if (instrUpdateStrobe)
        ir_r <= irShift_r;
    end
  end

  // Decode; unknown codes fall to bypass.
  wire selBscan = (ir_r == `BST_OP_EXTEST) | (ir_r == `BST_OP_SAMPLE);
  wire selId    = (ir_r == `BST_OP_IDCODE);
  wire selUser  = (ir_r == `BST_OP_USERCODE);
  wire selRc    = (ir_r == `BST_OP_RECONFIG);
  wire testMode = (ir_r == `BST_OP_EXTEST) | (ir_r == `BST_OP_CLAMP);
  wire highZ    = (ir_r == `BST_OP_HIGHZ);

  // ==========================================================================
  // Bypass, identification and reconfiguration registers
  // ==========================================================================
  reg                   bypass_r;
  reg [`BST_ID_LEN-1:0] id_r;
  reg [`BST_RC_LEN-1:0] rc_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bypass_r <= 1'b0;
      id_r     <= 32'h0;
      rc_r     <= 16'h0;
    end else begin
      if (dataCapture) begin
        bypass_r <= 1'b0;
        id_r     <= selUser ? `BST_USERCODE_VAL : `BST_IDCODE_VAL;
      end else if (dataShiftClock) begin
        bypass_r <= tdiS;
        id_r     <= {tdiS, id_r[`BST_ID_LEN-1:1]};
        if (selRc)
          rc_r <= {tdiS, rc_r[`BST_RC_LEN-1:1]};
      end
    end
  end

  // ==========================================================================
  // Boundary-scan chain
  // ==========================================================================
  // Cells 0..N_USER-1 are user pins, then clock, config, open-drain, push-pull.
  wire [NC:0]   chain;
  wire [NC-1:0] cOut;
  wire [NC-1:0] cOe;
  wire [NC-1:0] cPadIn;
  wire [NC-1:0] cPadOut;
  wire [NC-1:0] cPadOeN;
  wire [NC-1:0] cInDrv;

  assign chain[0] = tdiS;
  assign cOut     = {ppOutInt, 3'h0, coreOutputSignal};
  assign cOe      = {ppOeInt, odOeInt, 2'h0, coreOutputEnable};
  assign cPadIn   = padSync;

  // Test-port and supply pins are not in this list.
  genvar g;
  generate
    for (g = 0; g < NC; g = g + 1) begin : gCell
      localparam [2:0] K = (g < N_USER) ? `BST_KIND_USER :
                           (g == N_USER) ? `BST_KIND_CLKIN :
                           (g == N_USER + 1) ? `BST_KIND_CFGIN :
                           (g == N_USER + 2) ? `BST_KIND_ODBIDIR : `BST_KIND_PPBIDIR;
      bst_scan_cell #(.KIND(K)) uCell (
        .clk              (clk),
        .rst              (rst),
        .capEn            (dataCapture & selBscan),
        .shiftEn          (dataShiftClock & selBscan),
        .updateEn         (dataUpdateStrobe & selBscan),
        .testMode         (testMode),
        .cellSerialIn     (chain[g]),
        .cellSerialOut    (chain[g+1]),
        .coreOutputSignal (cOut[g]),
        .coreOutputEnable (cOe[g]),
        .padIn            (cPadIn[g]),
        .padOut           (cPadOut[g]),
        .padOeN           (cPadOeN[g]),
        .coreInputDrive   (cInDrv[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Serial output and pins
  // ==========================================================================
  reg drSel;

  always @* begin
    if (selBscan)
      drSel = chain[NC];
    else if (selId | selUser)
      drSel = id_r[0];
    else if (selRc)
      drSel = rc_r[0];
    else
      drSel = bypass_r;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo            <= 1'b0;
      tdoOe          <= 1'b0;
      padOut         <= {N_USER{1'b0}};
      padOe          <= {N_USER{1'b0}};
      coreInputDrive <= {N_USER{1'b0}};
      configHold     <= 1'b0;
      testLogicReset <= 1'b1;
    end else begin
      if (tckFall) begin
        tdo   <= instrShiftSelect ? irShift_r[0] : drSel;
        tdoOe <= instrShiftSelect | dataShiftSelect;
      end
      configHold     <= cfgS_r[1];
      testLogicReset <= state_r[0];
      coreInputDrive <= cInDrv[N_USER-1:0];
      padOut         <= cPadOut[N_USER-1:0];
      // Pad enable is active high at the port; cells carry the float flag.
      if (cfgS_r[1] | highZ)
        padOe <= {N_USER{1'b0}};
      else
        padOe <= ~cPadOeN[N_USER-1:0];
    end
  end

endmodule // bst_test_port

// *** testbench/bst_test_port_sva.sv ***
/*
 * Checker for the boundary-scan test port: timing of the serial output
 * against the test clock, state changes, and pin floating while configuring.
 * Assumes it is bound to bst_test_port and sees only its ports.
 */
`timescale 1ns/100ps

module bst_test_port_sva #(
  parameter N_USER = 4
) (
  // Clock and reset
  input wire              clk,
  input wire              rst,
  // Test port
  input wire              tck,
  input wire              tms,
  input wire              tdo,
  input wire              tdoOe,
  // User pins
  input wire [N_USER-1:0] coreOutputSignal,
  input wire [N_USER-1:0] coreOutputEnable,
  input wire [N_USER-1:0] padOut,
  input wire [N_USER-1:0] padOe,
  // Status
  input wire              configBusy,
  input wire              configHold,
  input wire              testLogicReset
);
  reg       tckQ;
  reg [3:0] fallAge;
  reg [3:0] riseAge;
  reg [2:0] tmsRun;

  // ==========================================================================
  // Clocks since the last raw test-clock edges, and high mode-select rises.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tckQ <= 1'b0;
      fallAge <= 4'hF;
      riseAge <= 4'hF;
      tmsRun <= 3'h0;
    end else begin
      tckQ <= tck;
      fallAge <= (tckQ & ~tck) ? 4'h0 : fallAge + {3'h0, fallAge != 4'hF};
      riseAge <= (~tckQ & tck) ? 4'h0 : riseAge + {3'h0, riseAge != 4'hF};
      if (~tckQ & tck) begin
        tmsRun <= tms ? tmsRun + {2'h0, tmsRun != 3'h7} : 3'h0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Assertions
  chk_tdo_fall:
    assert property ((tdoOe && $changed(tdo)) |-> (fallAge >= 4'h1 && fallAge <= 4'h5))
      else $error("tdo moved away from a tck fall");
  chk_oe_fall:
    assert property ($changed(tdoOe) |-> (fallAge >= 4'h1 && fallAge <= 4'h5))
      else $error("tdoOe moved away from a tck fall");
  chk_state_rise:
    assert property ($changed(testLogicReset) |-> (riseAge >= 4'h1 && riseAge <= 4'h5))
      else $error("state moved away from a tck rise");
  chk_five_tms:
    assert property ((riseAge == 4'h7 && tmsRun >= 3'h5) |-> testLogicReset)
      else $error("five high mode-select rises did not reach reset");
  chk_reset_float:
    assert property (testLogicReset |-> !tdoOe)
      else $error("tdo driven in reset state");
  chk_hold_follows:
    assert property (configBusy [*5] |-> configHold)
      else $error("configHold missed configBusy");
  chk_config_float:
    assert property ((configHold && $past(configHold)) |-> padOe == {N_USER{1'b0}})
      else $error("user pin driven while configuring");
  chk_normal_pads:
    assert property ((testLogicReset && $past(testLogicReset) && !$past(rst) && !configHold
        && !$past(configHold) && coreOutputEnable == $past(coreOutputEnable)
        && coreOutputSignal == $past(coreOutputSignal))
        |-> (padOe == ~coreOutputEnable && padOut == coreOutputSignal))
      else $error("pins not in normal operation in reset state");
endmodule // bst_test_port_sva

bind bst_test_port bst_test_port_sva #(.N_USER(N_USER)) chk_u (
  .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdo(tdo), .tdoOe(tdoOe),
  .coreOutputSignal(coreOutputSignal), .coreOutputEnable(coreOutputEnable),
  .padOut(padOut), .padOe(padOe), .configBusy(configBusy), .configHold(configHold),
  .testLogicReset(testLogicReset));

// *** testbench/bst_tester.sv ***
/*
 * Model of the external boundary-scan controller driving the test port.
 * Assumes a 25 MHz clk; the test clock has a 320 ns period and stands low
 * between frames, with mode select and data in held high there.
 */
`timescale 1ns/100ps

module bst_tester (
  // Reference clock
  input wire clk,
  // Test port
  output reg tck,
  output reg tms,
  output reg tdi,
  input wire tdo,
  input wire tdoOe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // ==========================================================================
  // One test-clock period; data out is taken just before the next fall.
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    tms = m;
    tdi = d;
    repeat (4) @(posedge clk);
    #1 tck = 1'b1;
    repeat (3) @(posedge clk);
    // A released data out has no pull; the model sees the opposite level.
    #1 q = tdoOe ? tdo : ~tdo;
    oe = tdoOe;
    @(posedge clk);
    #1 tck = 1'b0;
  endtask

  // From idle through a shift state and back to idle, LSB first.
  task automatic shift(input logic ir, input logic [63:0] din, input integer n,
                       output logic [63:0] dout, output logic [63:0] oes);
    logic   q;
    logic   o;
    integer i;
    dout = 64'h0;
    oes = 64'h0;
    step(1'b1, 1'b1, q, o);
    if (ir) begin
      step(1'b1, 1'b1, q, o);
    end
    step(1'b0, 1'b1, q, o);
    step(1'b0, 1'b1, q, o);
    for (i = 0; i < n; i = i + 1) begin
      step(i == n - 1, din[i], dout[i], oes[i]);
    end
    step(1'b1, 1'b1, q, o);
    oes[n] = o;
    step(1'b0, 1'b1, q, o);
    tms = 1'b1;
  endtask

  task automatic reset5;
    logic q;
    logic o;
    repeat (5) step(1'b1, 1'b1, q, o);
  endtask

  task automatic toIdle;
    logic q;
    logic o;
    step(1'b0, 1'b1, q, o);
    tms = 1'b1;
  endtask
endmodule // bst_tester

// *** testbench/tb_boundary_scan_test_port.sv ***
/*
 * Self-checking testbench for the boundary-scan test port.
 * Assumes bst_defs.vh on the include path and the bst_tester model.
 */
`timescale 1ns/100ps
`include "bst_defs.vh"

module tb_boundary_scan_test_port;
  reg          clk, rst, configBusy;
  reg  [3:0]   coreOutputSignal, coreOutputEnable, padIn;
  reg          clkPadIn, cfgPadIn, odPadIn, odOeInt, ppPadIn, ppOutInt, ppOeInt;
  wire         tck, tms, tdi, tdo, tdoOe, configHold, testLogicReset;
  wire [3:0]   coreInputDrive, padOut, padOe;
  integer      miscompares, nChecks;
  logic [63:0] dout, oes;

  bst_test_port #(.N_USER(4)) dut_u (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
    .coreOutputSignal(coreOutputSignal), .coreOutputEnable(coreOutputEnable),
    .coreInputDrive(coreInputDrive), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .clkPadIn(clkPadIn), .cfgPadIn(cfgPadIn), .odPadIn(odPadIn), .odOeInt(odOeInt),
    .ppPadIn(ppPadIn), .ppOutInt(ppOutInt), .ppOeInt(ppOeInt),
    .configBusy(configBusy), .configHold(configHold), .testLogicReset(testLogicReset));

  bst_tester tstr_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));

  // ==========================================================================
  // Helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nChecks = nChecks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Chain word (cell0 bit0 at 0) to serial order, last cell bit2 first.
  function automatic [63:0] rev24(input [23:0] v);
    integer k;
    rev24 = 64'h0;
    for (k = 0; k < 24; k = k + 1) rev24[k] = v[23 - k];
  endfunction

  task automatic w(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Dedicated inputs: {clk, cfg, od, odOe, pp, ppOut, ppOe}.
  task automatic pads(input [3:0] o, input [3:0] e, input [3:0] p, input [6:0] d);
    w(1);
    coreOutputSignal = o;
    coreOutputEnable = e;
    padIn = p;
    {clkPadIn, cfgPadIn, odPadIn, odOeInt, ppPadIn, ppOutInt, ppOeInt} = d;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_id;
    check(testLogicReset, 1'b1);
    check(tdoOe, 1'b0);
    tstr_u.toIdle;
    tstr_u.shift(1'b0, 64'h1, 40, dout, oes);
    check(dout, {31'h0, 1'b1, `BST_IDCODE_VAL});
    check(oes, 64'h000000FFFFFFFFFF);
  endtask

  task automatic t_codes;
    logic [9:0]  code [0:8];
    integer      len [0:8];
    logic [31:0] cap [0:8];
    logic [63:0] mask;
    integer      i;
    code = '{`BST_OP_BYPASS, 10'h155, `BST_OP_IDCODE, `BST_OP_USERCODE, `BST_OP_RECONFIG,
             `BST_OP_SAMPLE, `BST_OP_EXTEST, `BST_OP_CLAMP, `BST_OP_HIGHZ};
    len = '{1, 1, 32, 32, 16, 24, 24, 1, 1};
    cap = '{32'h0, 32'h0, `BST_IDCODE_VAL, `BST_USERCODE_VAL, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (i = 0; i < 9; i = i + 1) begin
      tstr_u.shift(1'b1, {54'h0, code[i]}, 10, dout, oes);
      check(dout, {54'h0, `BST_IR_CAPTURE});
      check(oes, 64'h3FF);
      tstr_u.shift(1'b0, 64'h1, len[i] + 8, dout, oes);
      mask = (64'h1 << len[i]) - 64'h1;
      check(dout & ~mask, 64'h1 << len[i]);
      if (len[i] != 16 && len[i] != 24) begin
        check(dout & mask, {32'h0, cap[i]});
      end
      if (code[i] === `BST_OP_HIGHZ) begin
        check(padOe, 4'h0);
      end
    end
  endtask

  task automatic t_sample_extest;
    pads(4'h0, 4'hF, 4'hF, 7'b1111101);
    tstr_u.shift(1'b1, {54'h0, `BST_OP_SAMPLE}, 10, dout, oes);
    tstr_u.shift(1'b0, 64'h0, 24, dout, oes);
    check(dout, rev24({8{3'b011}}));
    pads(4'hF, 4'h0, 4'h0, 7'b0001001);
    w(4);
    check({padOut, padOe}, 8'hFF);
    tstr_u.shift(1'b0, rev24({12'h0, 3'b001, 3'b110, 3'b010, 3'b101}), 24, dout, oes);
    check(dout, rev24({{4{3'b010}}, {4{3'b100}}}));
    tstr_u.shift(1'b1, {54'h0, `BST_OP_EXTEST}, 10, dout, oes);
    w(4);
    check({padOut, padOe, coreInputDrive}, 12'h599);
    tstr_u.reset5;
    w(4);
    check(testLogicReset, 1'b1);
    check({padOut, padOe}, 8'hFF);
  endtask

  task automatic t_config;
    w(1);
    configBusy = 1'b1;
    w(6);
    check({configHold, padOe}, 5'h10);
    configBusy = 1'b0;
    w(6);
    check({configHold, padOe}, 5'h0F);
  endtask

  // ==========================================================================
  // Run control
  task test_done;
    $display("checks %0d, miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #1000000;
    miscompares = miscompares + 1;
    test_done;
  end

  initial begin
    miscompares = 0;
    nChecks = 0;
    rst = 1'b1;
    configBusy = 1'b0;
    coreOutputSignal = 4'h3;
    coreOutputEnable = 4'h5;
    padIn = 4'h0;
    {clkPadIn, cfgPadIn, odPadIn, odOeInt, ppPadIn, ppOutInt, ppOeInt} = 7'h00;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    w(4);
    t_reset_id;
    t_codes;
    t_sample_extest;
    t_config;
    test_done;
  end
endmodule // tb_boundary_scan_test_port
